// ==== common/fcr_pkg.sv ====
// Package with register map, field layout and timing constants of the flash command register block.
package fcr_pkg;
  // Register byte offsets on APB.
  localparam logic [7:0] OFF_CMD_INDEX = 8'h00;
  localparam logic [7:0] OFF_ECC_INDEX = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_PROT = 8'h0C;
  localparam logic [7:0] OFF_CMD_WIN = 8'h10;
  localparam logic [7:0] OFF_RSV_A = 8'h14;
  localparam logic [7:0] OFF_RSV_B = 8'h18;
  localparam logic [7:0] OFF_ECC_WIN = 8'h1C;
  localparam logic [7:0] OFF_OPTION = 8'h20;
  localparam logic [7:0] OFF_RSV_C = 8'h24;
  localparam logic [7:0] OFF_RSV_D = 8'h28;
  localparam logic [7:0] OFF_RSV_E = 8'h2C;
  localparam logic [7:0] OFF_ECC_CLR = 8'h30;
  // Status and clear bit positions.
  localparam int BIT_CCF = 7;
  localparam int BIT_SFLT = 1;
  localparam int BIT_DFLT = 0;
  // Index values of the two windows.
  localparam logic [2:0] IDX_CMD = 3'h0;
  localparam logic [2:0] IDX_ADDR = 3'h1;
  localparam logic [2:0] IDX_DATA0 = 3'h2;
  localparam logic [2:0] IDX_DATA3 = 3'h5;
  localparam int NUM_WORDS = 6;
  // Protection region.
  localparam logic [22:0] DFLASH_BASE = 23'h10_0000;
  localparam int PROT_STEP_SHIFT = 8;
  // Option byte global address and its value on a double fault.
  localparam logic [22:0] OPTION_ADDR = 23'h7F_FF0E;
  localparam logic [7:0] OPTION_ALL_ONES = 8'hFF;
  localparam logic [7:0] DFLASH_PAR_MASK = 8'h3F;
  // Default command execution time.
  localparam int CMD_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CMD_CYCLES = (CMD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : fcr_pkg

// ==== logic/fcr_regs.sv ====
// Flash command object, ECC capture, option byte and reserved registers behind APB.
`timescale 1ns/100ps
module fcr_regs #(
  parameter int CMD_CYCLES = fcr_pkg::CMD_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic opt_load_valid,
  input wire logic [7:0] opt_load_byte,
  input wire logic opt_load_dfault,
  input wire logic ecc_sfault,
  input wire logic ecc_dfault,
  input wire logic ecc_is_dflash,
  input wire logic [22:0] ecc_addr,
  input wire logic [7:0] ecc_parity,
  input wire logic [63:0] ecc_data,
  input wire logic cmd_done,
  output logic cmd_start,
  output logic [7:0] cmd_code,
  output logic [22:0] cmd_addr,
  output logic [22:0] prot_end_addr,
  input wire logic res_we,
  input wire logic [2:0] res_idx,
  input wire logic [15:0] res_word
);
  // Elaboration checks.
  // The run counter is sixteen bits wide, so a longer command time cannot be served.
  // A zero command time would let the flag come back before the start pulse had been seen.
  // The word array and the index decode assume six words behind a three-bit index.
  // The protect decode assumes the step shift leaves the region inside the D-Flash window.
  initial begin
    if (CMD_CYCLES < 1 || CMD_CYCLES > 65535) begin
      $error("CMD_CYCLES out of range");
    end
    if (fcr_pkg::NUM_WORDS != 6) begin
      $error("NUM_WORDS must be six");
    end
    if (fcr_pkg::PROT_STEP_SHIFT > 14) begin
      $error("PROT_STEP_SHIFT too large");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode.
  // All internal state of the block is declared here, grouped by concern.
  // The command words form a small array held in flops, because the engine
  // reads the command code and address from them for the whole run.
  // The capture registers keep the fault details, D-Flash ones masked; the visible word is
  // chosen later by the ECC index, so no data is lost by reading.
  // The run counter and the running flag form the minimum-time guard
  // between a launch and the return of the command-complete flag.
  logic access;
  logic wr;
  logic [15:0] cmd_words [fcr_pkg::NUM_WORDS];
  logic [2:0] cmd_idx_reg;
  logic [2:0] ecc_idx_reg;
  logic ccf_reg;
  logic [4:0] prot_reg;
  logic [7:0] option_reg;
  logic sflt_reg;
  logic dflt_reg;
  logic [7:0] cap_par_reg;
  logic [22:0] cap_addr_reg;
  logic [63:0] cap_data_reg;
  logic cap_dfl_reg;
  logic [15:0] run_cnt_reg;
  logic running_reg;

  // Writes take effect in the access phase; the slave answers with no wait state.
  // Because pready is high in the first access cycle, one access cycle is the
  // only cycle in which access is true, so every write lands exactly once.
  // The clock enable is folded in here so that a frozen block ignores the bus.
  assign access = psel & penable & clk_en;
  assign wr = access & pwrite;

  // Merges byte lanes of a write into a 16-bit word.
  // Only the two low lanes carry window data; the upper lanes are ignored,
  // so software may use byte, half-word or word stores alike.
  // A lane that is not strobed keeps the old byte of the word.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = old;
    if (s[0]) begin
      merge16[7:0] = d[7:0];
    end
    if (s[1]) begin
      merge16[15:8] = d[15:8];
    end
  endfunction : merge16

  // True when the access selects a given register offset.
  // Kept as a function so every write decode compares the address the same way.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Index and protection registers.
  // These are plain byte registers written through lane zero.
  // The indices are three bits wide, so every value is legal; the unused
  // positions are handled by the read path, not by refusing the write.
  // The protect size code is kept here and decoded in its own process.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_idx_reg <= 3'h0;
      ecc_idx_reg <= 3'h0;
      prot_reg <= 5'h00;
    end else if (wr && pstrb[0]) begin
      if (hit(paddr, fcr_pkg::OFF_CMD_INDEX)) begin
        cmd_idx_reg <= pwdata[2:0];
      end
      if (hit(paddr, fcr_pkg::OFF_ECC_INDEX)) begin
        ecc_idx_reg <= pwdata[2:0];
      end
      if (hit(paddr, fcr_pkg::OFF_PROT)) begin
        prot_reg <= pwdata[4:0];
      end
    end
  end

  // Protected region end address: base plus 256 bytes per code step.
  // The region always starts at the D-Flash base, so only the end is decoded.
  // The result is registered so that the output comes straight from a flop;
  // it therefore follows a new code one clock later.
  // The arithmetic is done at the width of the address and cut on purpose.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prot_end_addr <= 23'h0;
    end else if (clk_en) begin
      prot_end_addr <= fcr_pkg::DFLASH_BASE + 23'((({18'h0, prot_reg} + 23'h1) << fcr_pkg::PROT_STEP_SHIFT) - 23'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command launch and completion.
  // A launch is a write of 1 to the flag bit while the flag is 1.
  // Writing 1 while a command runs does nothing, so a second launch cannot
  // overtake the first; writing 0 never touches the flag.
  logic launch;
  assign launch = wr && hit(paddr, fcr_pkg::OFF_STATUS) && pstrb[0] && pwdata[fcr_pkg::BIT_CCF] && ccf_reg;

  // Flag, start pulse and run counter.
  // The counter enforces a minimum run time even if the engine reports done
  // at once, which keeps the lock window long enough for the engine to copy
  // its parameters. The flag returns only when both conditions hold.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ccf_reg <= 1'b1;
      cmd_start <= 1'b0;
      running_reg <= 1'b0;
      run_cnt_reg <= 16'h0000;
    end else if (clk_en) begin
      cmd_start <= launch;
      if (launch) begin
        ccf_reg <= 1'b0;
        running_reg <= 1'b1;
        run_cnt_reg <= 16'(CMD_CYCLES);
      end else if (running_reg) begin
        if (run_cnt_reg != 16'h0000) begin
          run_cnt_reg <= run_cnt_reg - 16'h0001;
        end
        if (cmd_done && run_cnt_reg <= 16'h0001) begin
          ccf_reg <= 1'b1;
          running_reg <= 1'b0;
        end
      end
    end
  end

  // Command code and target address for the engine.
  // They are fixed slices of the word flops, so they are glitch free; software writes
  // are locked during the run, but an engine result write to word 0 or 1 changes them.
  assign cmd_code = cmd_words[fcr_pkg::IDX_CMD][15:8];
  assign cmd_addr = {cmd_words[fcr_pkg::IDX_CMD][6:0], cmd_words[fcr_pkg::IDX_ADDR]};

  // Command object words, one process per word.
  // The engine may write results only while a command runs, and software
  // only while the flag is 1, so the two writers never meet in one cycle.
  // On software writes, bit 7 of word 0 is forced to zero because it sits above the address.
  for (genvar i = 0; i < fcr_pkg::NUM_WORDS; i++) begin : g_cmd
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        cmd_words[i] <= 16'h0000;
      end else if (clk_en) begin
        if (res_we && !ccf_reg && res_idx == 3'(i)) begin
          cmd_words[i] <= res_word;
        end else if (wr && ccf_reg && hit(paddr, fcr_pkg::OFF_CMD_WIN) && cmd_idx_reg == 3'(i)) begin
          cmd_words[i] <= merge16(cmd_words[i], pwdata, pstrb);
          if (i == 0) begin
            cmd_words[i][7] <= 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ECC fault capture.
  // Clears are write-one per flag, so software may clear one kind of fault
  // while the other stays held.
  // A double fault may replace held single details, never the reverse, and
  // a single fault that arrives with a double one is dropped.
  logic clr_s;
  logic clr_d;
  logic take_d;
  logic take_s;
  assign clr_s = wr && hit(paddr, fcr_pkg::OFF_ECC_CLR) && pstrb[0] && pwdata[fcr_pkg::BIT_SFLT];
  assign clr_d = wr && hit(paddr, fcr_pkg::OFF_ECC_CLR) && pstrb[0] && pwdata[fcr_pkg::BIT_DFLT];
  assign take_d = ecc_dfault && !dflt_reg;
  assign take_s = ecc_sfault && !ecc_dfault && !sflt_reg && !dflt_reg;

  // Fault flags: a new fault wins over a clear in the same cycle.
  // Losing a fault to a clear would let fresh details be overwritten unseen.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sflt_reg <= 1'b0;
      dflt_reg <= 1'b0;
    end else if (clk_en) begin
      sflt_reg <= ecc_sfault | (sflt_reg & ~clr_s);
      dflt_reg <= ecc_dfault | (dflt_reg & ~clr_d);
    end
  end

  // Captured details.
  // D-Flash faults carry six parity bits and one data word, so the rest is
  // cleared at capture and reads back as zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_par_reg <= 8'h00;
      cap_addr_reg <= 23'h0;
      cap_data_reg <= 64'h0;
      cap_dfl_reg <= 1'b0;
    end else if (clk_en && (take_d || take_s)) begin
      cap_par_reg <= ecc_is_dflash ? (ecc_parity & fcr_pkg::DFLASH_PAR_MASK) : ecc_parity;
      cap_addr_reg <= ecc_addr;
      cap_data_reg <= ecc_is_dflash ? {48'h0, ecc_data[15:0]} : ecc_data;
      cap_dfl_reg <= ecc_is_dflash;
    end
  end

  // Visible ECC word.
  // Bit 7 of word 0 has no meaning and reads as zero.
  logic [15:0] ecc_word;
  always_comb begin
    unique case (ecc_idx_reg)
      3'h0: ecc_word = {cap_par_reg, 1'b0, cap_addr_reg[22:16]};
      3'h1: ecc_word = cap_addr_reg[15:0];
      3'h2: ecc_word = cap_data_reg[15:0];
      3'h3: ecc_word = cap_dfl_reg ? 16'h0000 : cap_data_reg[31:16];
      3'h4: ecc_word = cap_dfl_reg ? 16'h0000 : cap_data_reg[47:32];
      3'h5: ecc_word = cap_dfl_reg ? 16'h0000 : cap_data_reg[63:48];
      default: ecc_word = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Option byte, loaded by the reset sequence.
  // Software has no write path to this register at all.
  // A double fault on the load sets every bit, the safe default for options.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      option_reg <= 8'h00;
    end else if (clk_en && opt_load_valid) begin
      option_reg <= opt_load_dfault ? fcr_pkg::OPTION_ALL_ONES : opt_load_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and bus answer.
  // The command window reads zero at the two unused index positions.
  logic [15:0] cmd_word;
  assign cmd_word = (cmd_idx_reg > fcr_pkg::IDX_DATA3) ? 16'h0000 : cmd_words[cmd_idx_reg];

  logic [31:0] rd_next;
  logic err_next;
  always_comb begin
    rd_next = 32'h0000_0000;
    err_next = 1'b0;
    unique case (paddr)
      fcr_pkg::OFF_CMD_INDEX: rd_next = {29'h0, cmd_idx_reg};
      fcr_pkg::OFF_ECC_INDEX: rd_next = {29'h0, ecc_idx_reg};
      fcr_pkg::OFF_STATUS: rd_next = {24'h0, ccf_reg, 7'h0};
      fcr_pkg::OFF_PROT: rd_next = {27'h0, prot_reg};
      fcr_pkg::OFF_CMD_WIN: rd_next = {16'h0, cmd_word};
      fcr_pkg::OFF_ECC_WIN: rd_next = {16'h0, ecc_word};
      fcr_pkg::OFF_OPTION: rd_next = {24'h0, option_reg};
      fcr_pkg::OFF_ECC_CLR: rd_next = {30'h0, sflt_reg, dflt_reg};
      fcr_pkg::OFF_RSV_A, fcr_pkg::OFF_RSV_B, fcr_pkg::OFF_RSV_C,
      fcr_pkg::OFF_RSV_D, fcr_pkg::OFF_RSV_E: rd_next = 32'h0000_0000;
      default: err_next = 1'b1;
    endcase
  end

  // Registered answer: pready rises in the first access cycle and drops after it.
  // Read data is taken in the setup cycle and held until the next read, so it
  // stands at the edge where the master samples pready.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & err_next;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_next;
      end
    end
  end
endmodule : fcr_regs

// ==== dv/fcr_regs_properties.sv ====
// Concurrent checks on the ports of the flash command register block.
`timescale 1ns/100ps
module fcr_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cmd_start,
  input wire logic [7:0] cmd_code,
  input wire logic [22:0] prot_end_addr
);
  // All checks share the bus clock and its reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_ready_after_setup: assert property (psel && !penable && clk_en |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (pready && paddr > 8'h30 |-> pslverr)
    else $error("no error on unmapped address");
  a_rsv_reads_zero: assert property (pready && !pwrite && paddr inside {8'h14, 8'h18, 8'h24, 8'h28, 8'h2C}
    |-> prdata == 32'h0)
    else $error("reserved register not zero");
  a_start_cause: assert property ($rose(cmd_start) |-> $past(psel && penable && pwrite && paddr == 8'h08)
    || $past(psel && penable && pwrite && paddr == 8'h08, 2))
    else $error("start without launch write");
  a_start_pulse: assert property (cmd_start |=> !cmd_start)
    else $error("start longer than one cycle");
  a_code_locked: assert property (cmd_start |=> $stable(cmd_code))
    else $error("command code changed at launch");
  a_prot_range: assert property (prot_end_addr != 23'h0 |-> prot_end_addr[7:0] == 8'hFF
    && prot_end_addr[22:13] == 10'h080)
    else $error("protect end out of range");
endmodule : fcr_chk
bind fcr_regs fcr_chk i_chk (.*);

// ==== dv/fcr_regs_tb.sv ====
// Self-checking bench for the flash command register block.
`timescale 1ns/100ps
module fcr_regs_tb;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic clk_en = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er, pready, pslverr, cmd_start, cmd_done = 1'h0;
  logic opt_load_valid = 1'h0, opt_load_dfault = 1'h0, ecc_sfault = 1'h0, ecc_dfault = 1'h0;
  logic ecc_is_dflash = 1'h0, res_we = 1'h0;
  logic [7:0] paddr = 8'h0, opt_load_byte = 8'h0, ecc_parity = 8'h0, cmd_code;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic [22:0] ecc_addr = 23'h0, cmd_addr, prot_end_addr;
  logic [63:0] ecc_data = 64'h0;
  logic [2:0] res_idx = 3'h0;
  logic [15:0] res_word = 16'h0;
  int err_count = 0;
  int n_checks = 0;
  // Device under test with a short command time.
  fcr_regs #(.CMD_CYCLES(2)) i_dut (.*);
  // Free-running 100 MHz clock.
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  // One APB transfer, held until pready is seen at a rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (n >= 16) begin
      err_count++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d, 4'hF);
  endtask : wr
  // Reads a register and compares the masked value.
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'h0, a, 32'h0, 4'h0);
    chk(nm, rd & m, e);
  endtask : rdc
  // Selects an ECC word and compares it.
  task automatic ecc(input logic [2:0] i, input logic [15:0] e);
    wr(8'h04, {29'h0, i});
    rdc("ecc_window", 8'h1C, 32'hFFFF, {16'h0, e});
  endtask : ecc
  // Pulses the fault inputs for one cycle with the given details.
  task automatic fault(input logic s, input logic d, input logic f, input logic [22:0] a, input logic [7:0] p,
    input logic [63:0] x);
    @(posedge clk);
    ecc_sfault <= s;
    ecc_dfault <= d;
    ecc_is_dflash <= f;
    ecc_addr <= a;
    ecc_parity <= p;
    ecc_data <= x;
    @(posedge clk);
    ecc_sfault <= 1'h0;
    ecc_dfault <= 1'h0;
  endtask : fault
  // Pulses the option load with the given byte and fault state.
  task automatic load(input logic [7:0] b, input logic df);
    @(posedge clk);
    opt_load_byte <= b;
    opt_load_dfault <= df;
    opt_load_valid <= 1'h1;
    @(posedge clk);
    opt_load_valid <= 1'h0;
  endtask : load
  ////////////////////////////////////////////////////////////////
  // Reset flag, reserved registers and an unmapped access.
  task automatic t_regs;
    logic [7:0] rsv [5];
    rsv = '{8'h14, 8'h18, 8'h24, 8'h28, 8'h2C};
    rdc("flag", 8'h08, 32'h80, 32'h80);
    foreach (rsv[k]) begin
      wr(rsv[k], 32'hFFFF_FFFF);
      rdc("reserved", rsv[k], 32'hFFFF_FFFF, 32'h0);
    end
    bus(1'h0, 8'h40, 32'h0, 4'h0);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    $display("test regs done");
  endtask : t_regs
  // Option byte load, write refusal and double fault.
  task automatic t_opt;
    rdc("option", 8'h20, 32'hFF, 32'h0);
    load(8'hA5, 1'h0);
    rdc("option", 8'h20, 32'hFF, 32'hA5);
    wr(8'h20, 32'h5A);
    rdc("option", 8'h20, 32'hFF, 32'hA5);
    load(8'h12, 1'h1);
    rdc("option", 8'h20, 32'hFF, 32'hFF);
    $display("test opt done");
  endtask : t_opt
  // Upper protect size codes.
  task automatic t_prot;
    for (int n = 22; n < 32; n++) begin
      wr(8'h0C, 32'(n));
      repeat (2) @(posedge clk);
      chk("prot_end", {9'h0, prot_end_addr}, 32'h10_0000 + 32'((n + 1) << 8) - 32'h1);
    end
    $display("test prot done");
  endtask : t_prot
  // Command words, byte write, launch, lock and result.
  task automatic t_cmd;
    logic [15:0] e;
    int n;
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, 32'(i));
      wr(8'h10, 32'h9A80 | 32'(i));
      e = (i > 5) ? 16'h0 : (i == 0) ? 16'h9A00 : 16'h9A80 | 16'(i);
      rdc("cmd_window", 8'h10, 32'hFFFF, {16'h0, e});
    end
    chk("cmd_code", {24'h0, cmd_code}, 32'h9A);
    chk("cmd_addr", {9'h0, cmd_addr}, 32'h9A81);
    wr(8'h00, 32'h2);
    bus(1'h1, 8'h10, 32'h1234, 4'h1);
    rdc("byte_write", 8'h10, 32'hFFFF, 32'h9A34);
    wr(8'h08, 32'h80);
    n = 0;
    while (cmd_start !== 1'h1 && n < 4) begin
      @(posedge clk);
      n++;
    end
    chk("cmd_start", 32'(n < 4), 32'h1);
    rdc("flag", 8'h08, 32'h80, 32'h0);
    wr(8'h10, 32'h5555);
    rdc("locked", 8'h10, 32'hFFFF, 32'h9A34);
    @(posedge clk);
    res_we <= 1'h1;
    res_idx <= 3'h2;
    res_word <= 16'hBEEF;
    @(posedge clk);
    res_we <= 1'h0;
    cmd_done <= 1'h1;
    n = 0;
    rd = 32'h0;
    while (rd[7] !== 1'h1 && n < 16) begin
      bus(1'h0, 8'h08, 32'h0, 4'h0);
      n++;
    end
    chk("flag_back", rd & 32'h80, 32'h80);
    cmd_done <= 1'h0;
    rdc("result", 8'h10, 32'hFFFF, 32'hBEEF);
    wr(8'h10, 32'h5555);
    rdc("unlocked", 8'h10, 32'hFFFF, 32'h5555);
    $display("test cmd done");
  endtask : t_cmd
  // Fault capture, hold, replacement and priority.
  task automatic t_ecc;
    fault(1'h1, 1'h0, 1'h0, 23'h12_3456, 8'hC7, 64'h4444_3333_2222_1111);
    ecc(3'h0, 16'hC712);
    ecc(3'h1, 16'h3456);
    ecc(3'h2, 16'h1111);
    ecc(3'h5, 16'h4444);
    ecc(3'h6, 16'h0);
    ecc(3'h7, 16'h0);
    fault(1'h1, 1'h0, 1'h0, 23'h00_0001, 8'h01, 64'h0);
    ecc(3'h1, 16'h3456);
    fault(1'h0, 1'h1, 1'h1, 23'h10_0ABC, 8'hFF, 64'hBEEF);
    ecc(3'h0, 16'h3F10);
    ecc(3'h2, 16'hBEEF);
    ecc(3'h3, 16'h0);
    rdc("fault_flags", 8'h30, 32'h3, 32'h3);
    wr(8'h30, 32'h3);
    rdc("flags_clear", 8'h30, 32'h3, 32'h0);
    fault(1'h1, 1'h1, 1'h0, 23'h00_0777, 8'h00, 64'h0);
    ecc(3'h1, 16'h0777);
    $display("test ecc done");
  endtask : t_ecc
  ////////////////////////////////////////////////////////////////
  // Main sequence after a four-cycle reset.
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    t_regs();
    t_opt();
    t_prot();
    t_cmd();
    t_ecc();
    test_done();
  end
endmodule : fcr_regs_tb
